// ===== logic/itg_pkg.sv
// shared constants and types of the interval timer interrupt block
package itg_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned SRC_CLK_HZ = 10_000_000;
  localparam int unsigned SRC_PERIOD_NS = 100;
  localparam int unsigned SYS_PERIOD_NS = 10;
  // system cycles per count-source period
  localparam int unsigned SRC_DIV = SRC_PERIOD_NS / SYS_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte addresses (low 16 address bits decoded)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ST_EN = 16'h4010;
  localparam logic [15:0] ADDR_ST_CLR = 16'h4014;
  localparam logic [15:0] ADDR_LOC_ST = 16'h4018;
  localparam logic [15:0] ADDR_LOC_MASK = 16'h401C;
  localparam logic [15:0] ADDR_CH_BASE = 16'h4020;
  localparam logic [15:0] CH_STRIDE = 16'h0008;
  localparam logic [15:0] CH_MODE_OFS = 16'h0000;
  localparam logic [15:0] CH_COUNT_OFS = 16'h0004;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ST_THIRD_BIT = 0;
  localparam int unsigned ST_SLOW_BIT = 1;
  localparam int unsigned EN_THIRD_BIT = 4;
  localparam int unsigned EN_SLOW_BIT = 5;
  localparam int unsigned LOC_FAST_BIT = 0;
  localparam logic RST_EN = 1'b0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // channel numbering and mode codes
  localparam int unsigned CH_THIRD = 0;
  localparam int unsigned CH_FAST = 1;
  localparam int unsigned CH_SLOW = 2;
  localparam logic [2:0] MODE_TC = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // per-channel programming
  typedef struct packed {
    logic [2:0] mode;
    logic [15:0] count;
  } itg_cfg_t;

endpackage : itg_pkg

// ===== logic/itg_edge_sync.sv
// two-stage synchroniser with rising-edge detect, one lane per bit
`timescale 1ns/1ns
module itg_edge_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);

  if (WIDTH < 1) begin : g_chk
    $error("itg_edge_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // per-bit lanes
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    logic meta_q;
    logic sync_q;
    logic prev_q;
    // first stage feeds only the second one
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        meta_q <= din_i[i];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end
    assign level_o[i] = sync_q;
    assign rise_o[i] = sync_q & ~prev_q;
  end

endmodule : itg_edge_sync

// ===== logic/itg_tmr_chan.sv
// one interval timer channel: terminal count, one-shot, square wave
`timescale 1ns/1ns
module itg_tmr_chan (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic gate_i,
  input wire logic gate_rise_i,
  input wire logic load_i,
  input wire itg_pkg::itg_cfg_t cfg_i,
  output logic out_o
);

  logic [15:0] cnt_q;
  logic armed_q;
  logic out_q;
  logic [15:0] hi_half;
  logic [15:0] lo_half;

  // square wave splits the count, odd counts give the extra tick high
  assign hi_half = 16'((17'(cfg_i.count) + 17'h0_0001) >> 1);
  assign lo_half = cfg_i.count >> 1;
  assign out_o = out_q;

  // ----------------------------------------------------------------
  // counter and output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= itg_pkg::RST_COUNT;
      armed_q <= 1'b0;
      out_q <= 1'b0;
    end else if (load_i) begin
      cnt_q <= (cfg_i.mode == itg_pkg::MODE_SQUARE) ? hi_half : cfg_i.count;
      armed_q <= (cfg_i.mode == itg_pkg::MODE_TC);
      out_q <= (cfg_i.mode != itg_pkg::MODE_TC);
    end else begin
      unique case (cfg_i.mode)
        itg_pkg::MODE_ONESHOT: begin
          if (gate_rise_i) begin
            // each gate pulse restarts the countdown
            cnt_q <= cfg_i.count;
            armed_q <= 1'b1;
            out_q <= 1'b0;
          end else if (tick_i && armed_q) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              armed_q <= 1'b0;
              out_q <= 1'b1;
            end
          end
        end
        itg_pkg::MODE_SQUARE: begin
          if (tick_i && gate_i) begin
            if (cnt_q == 16'h0001) begin
              out_q <= ~out_q;
              cnt_q <= out_q ? lo_half : hi_half;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        default: begin
          // terminal count, also taken for unused mode codes
          if (tick_i && gate_i && armed_q) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              armed_q <= 1'b0;
              out_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_TC_LOW_ON_LOAD: assert property (@(posedge mclk_i) disable iff (rst_i)
    load_i && cfg_i.mode == itg_pkg::MODE_TC |=> !out_q)
    else $error("terminal count output not low after load");
  AST_SQ_TOGGLE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !load_i && cfg_i.mode == itg_pkg::MODE_SQUARE && tick_i && gate_i && cnt_q == 16'h0001
      |=> out_q != $past(out_q))
    else $error("square wave did not toggle at end of half period");
  AST_ONESHOT_TRIG: assert property (@(posedge mclk_i) disable iff (rst_i)
    !load_i && cfg_i.mode == itg_pkg::MODE_ONESHOT && gate_rise_i |=> !out_q && armed_q)
    else $error("one-shot did not start on gate edge");

endmodule : itg_tmr_chan

// ===== logic/itg_timer_irq.sv
// interval timer subsystem with interrupt glue and an AHB-Lite register slave
`timescale 1ns/1ns
module itg_timer_irq (
  input wire logic mclk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // backplane rear connector loopback
  input wire logic loop_clk_i,
  input wire logic loop_gate_i,
  output logic fast_out_o,
  output logic slow_out_o,
  output logic third_out_o,
  output logic irq_o
);

  localparam int unsigned NCH = 3;

  typedef enum logic {
    ITG_BUS_IDLE,
    ITG_BUS_WAIT
  } itg_bus_t;

  itg_bus_t bus_q;
  logic [15:0] addr_q;
  logic wr_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic wr_fire;
  logic rd_fire;
  logic en_third_q;
  logic en_slow_q;
  logic [1:0] st_q;
  logic loc_st_q;
  logic loc_mask_q;
  logic irq_q;
  logic rd_clr;
  logic irq_src;
  logic [3:0] div_q;
  logic div_tick;
  itg_pkg::itg_cfg_t cfg_q [NCH];
  logic [NCH-1:0] load_q;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] gate;
  logic [NCH-1:0] gate_rise;
  logic [NCH-1:0] tmr_out;
  logic [4:0] sync_level;
  logic [4:0] sync_rise;
  logic [NCH-1:0] out_rise;
  logic [31:0] rd_mux;

  if (itg_pkg::SRC_DIV < 2 || itg_pkg::SRC_DIV > 16) begin : g_chk
    $error("itg_timer_irq: divider out of range for its counter");
  end

  // ----------------------------------------------------------------
  // count source divider
  // ----------------------------------------------------------------
  // one-cycle pulse every source period instead of a second clock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 4'h0;
    end else if (div_q == 4'(itg_pkg::SRC_DIV - 1)) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign div_tick = (div_q == 4'(itg_pkg::SRC_DIV - 1));

  // ----------------------------------------------------------------
  // synchronisers and edge detect
  // ----------------------------------------------------------------
  // timer outputs go through the same path as the pins so that all
  // status timing is alike; costs two cycles of latency
  itg_edge_sync #(
    .WIDTH(5)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .din_i({loop_gate_i, loop_clk_i, tmr_out}),
    .level_o(sync_level),
    .rise_o(sync_rise)
  );
  assign out_rise = sync_rise[NCH-1:0];

  // channel sources
  always_comb begin
    tick = {div_tick, div_tick, sync_rise[3]};
    gate = {1'b1, 1'b1, sync_level[4]};
    gate_rise = {1'b0, 1'b0, sync_rise[4]};
  end

  // ----------------------------------------------------------------
  // timer channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    itg_tmr_chan u_chan (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick[c]),
      .gate_i(gate[c]),
      .gate_rise_i(gate_rise[c]),
      .load_i(load_q[c]),
      .cfg_i(cfg_q[c]),
      .out_o(tmr_out[c])
    );
  end
  // connector pins carry fast as clock and slow as gate back in
  assign fast_out_o = tmr_out[itg_pkg::CH_FAST];
  assign slow_out_o = tmr_out[itg_pkg::CH_SLOW];
  assign third_out_o = tmr_out[itg_pkg::CH_THIRD];

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  // every NONSEQ transfer gets one wait state so a read sees prior writes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= ITG_BUS_IDLE;
      addr_q <= 16'h0000;
      wr_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      unique case (bus_q)
        ITG_BUS_IDLE: begin
          if (hsel_i && hready_i && htrans_i == itg_pkg::HTRANS_NONSEQ) begin
            bus_q <= ITG_BUS_WAIT;
            addr_q <= haddr_i[15:0];
            wr_q <= hwrite_i;
            ready_q <= 1'b0;
          end
        end
        ITG_BUS_WAIT: begin
          bus_q <= ITG_BUS_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end
  assign wr_fire = (bus_q == ITG_BUS_WAIT) && wr_q;
  assign rd_fire = (bus_q == ITG_BUS_WAIT) && !wr_q;
  assign rd_clr = rd_fire && addr_q == itg_pkg::ADDR_ST_CLR;
  assign hreadyout_o = ready_q;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped addresses read as zero with an OKAY answer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == itg_pkg::ADDR_ST_EN || addr_q == itg_pkg::ADDR_ST_CLR) begin
      rd_mux[itg_pkg::ST_THIRD_BIT] = st_q[0];
      rd_mux[itg_pkg::ST_SLOW_BIT] = st_q[1];
      rd_mux[itg_pkg::EN_THIRD_BIT] = en_third_q;
      rd_mux[itg_pkg::EN_SLOW_BIT] = en_slow_q;
    end else if (addr_q == itg_pkg::ADDR_LOC_ST) begin
      rd_mux[itg_pkg::LOC_FAST_BIT] = loc_st_q;
    end else if (addr_q == itg_pkg::ADDR_LOC_MASK) begin
      rd_mux[itg_pkg::LOC_FAST_BIT] = loc_mask_q;
    end
    for (int c = 0; c < NCH; c++) begin
      if (addr_q == 16'(itg_pkg::ADDR_CH_BASE + 16'(c) * itg_pkg::CH_STRIDE + itg_pkg::CH_MODE_OFS)) begin
        rd_mux = {28'h000_0000, tmr_out[c], cfg_q[c].mode};
      end
      if (addr_q == 16'(itg_pkg::ADDR_CH_BASE + 16'(c) * itg_pkg::CH_STRIDE + itg_pkg::CH_COUNT_OFS)) begin
        rd_mux = {16'h0000, cfg_q[c].count};
      end
    end
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // enables, toggled only, the data is ignored
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      en_third_q <= itg_pkg::RST_EN;
      en_slow_q <= itg_pkg::RST_EN;
    end else if (wr_fire) begin
      if (addr_q == itg_pkg::ADDR_ST_EN) begin
        en_third_q <= ~en_third_q;
      end
      if (addr_q == itg_pkg::ADDR_ST_CLR) begin
        en_slow_q <= ~en_slow_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status, a new edge beats the read clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= 2'b00;
    end else begin
      st_q[0] <= (st_q[0] & ~rd_clr) | out_rise[itg_pkg::CH_THIRD];
      st_q[1] <= (st_q[1] & ~rd_clr) | out_rise[itg_pkg::CH_SLOW];
    end
  end

  // local input of the fast channel: edge-held, write one to clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      loc_st_q <= 1'b0;
      loc_mask_q <= 1'b0;
    end else begin
      if (out_rise[itg_pkg::CH_FAST]) begin
        loc_st_q <= 1'b1;
      end else if (wr_fire && addr_q == itg_pkg::ADDR_LOC_ST && hwdata_i[itg_pkg::LOC_FAST_BIT]) begin
        loc_st_q <= 1'b0;
      end
      if (wr_fire && addr_q == itg_pkg::ADDR_LOC_MASK) begin
        loc_mask_q <= hwdata_i[itg_pkg::LOC_FAST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // channel programming
  // ----------------------------------------------------------------
  // writing the count reloads and restarts the channel, except one-shot, which waits for a gate edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        cfg_q[c] <= '{mode: itg_pkg::RST_MODE, count: itg_pkg::RST_COUNT};
      end
      load_q <= '0;
    end else begin
      load_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        if (wr_fire && addr_q == 16'(itg_pkg::ADDR_CH_BASE + 16'(c) * itg_pkg::CH_STRIDE
            + itg_pkg::CH_MODE_OFS)) begin
          cfg_q[c].mode <= hwdata_i[2:0];
        end
        if (wr_fire && addr_q == 16'(itg_pkg::ADDR_CH_BASE + 16'(c) * itg_pkg::CH_STRIDE
            + itg_pkg::CH_COUNT_OFS)) begin
          cfg_q[c].count <= hwdata_i[15:0];
          load_q[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  assign irq_src = (st_q[0] & en_third_q) | (st_q[1] & en_slow_q) | (loc_st_q & loc_mask_q);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_src;
    end
  end
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wr_en;
    wr_fire && addr_q == itg_pkg::ADDR_ST_EN;
  endsequence
  sequence s_wr_clr;
    wr_fire && addr_q == itg_pkg::ADDR_ST_CLR;
  endsequence

  // ten cycles between ticks: nine quiet cycles, split to keep the repeat short
  AST_SRC_PERIOD: assert property (div_tick |=> !div_tick [*8] ##1 !div_tick ##1 div_tick)
    else $error("count source period not ten cycles");
  // a loop clock rise reaches the third channel after the two sync stages
  AST_THIRD_SRC: assert property ($rose(loop_clk_i) |-> ##2 tick[itg_pkg::CH_THIRD])
    else $error("third channel not clocked from loopback");
  AST_EN4_TOGGLE: assert property (s_wr_en |=> en_third_q != $past(en_third_q))
    else $error("write to first address did not toggle bit 4");
  AST_EN5_TOGGLE: assert property (s_wr_clr |=> en_slow_q != $past(en_slow_q))
    else $error("write to second address did not toggle bit 5");
  AST_EN_HELD: assert property (!wr_fire |=> $stable(en_third_q) && $stable(en_slow_q))
    else $error("enable changed without a write");
  AST_RD_CLEAR: assert property (rd_clr && out_rise[0] == 1'b0 && out_rise[2] == 1'b0 |=> st_q == 2'b00)
    else $error("read of second address did not clear status");
  AST_THIRD_SET: assert property (out_rise[itg_pkg::CH_THIRD] |=> st_q[0])
    else $error("third channel edge lost");
  AST_SLOW_MASKED: assert property (out_rise[itg_pkg::CH_SLOW] && !en_slow_q && !wr_fire && irq_src == 1'b0
    |=> st_q[1] ##1 !irq_o)
    else $error("disabled slow edge raised interrupt or lost status");
  AST_LOCAL_GATE: assert property (loc_st_q && loc_mask_q |=> irq_o)
    else $error("enabled local input did not interrupt");
  AST_IRQ_CAUSE: assert property (irq_o |-> $past(irq_src))
    else $error("interrupt without enabled status");
  AST_IRQ_RAISE: assert property ($rose(st_q[0]) && en_third_q && !wr_fire |=> irq_o)
    else $error("enabled third channel edge gave no interrupt");

endmodule : itg_timer_irq

// ===== testbench/itg_loop_model.sv
// connector loopback model feeding the third channel from the other two
`timescale 1ns/1ns
module itg_loop_model (
  input wire logic fast_i,
  input wire logic slow_i,
  output logic clk_o,
  output logic gate_o
);
  // plain jumpers with no delay; the block synchronises them itself
  assign clk_o = fast_i;
  assign gate_o = slow_i;
endmodule : itg_loop_model

// ===== testbench/tb.sv
// self-checking bench of the interval timer interrupt block
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic lclk, lgate, fast, slow, third, irq;
  logic [31:0] rd;
  int mismatches = 0;
  int checks = 0;
  int seed = 63629;
  int cyc = 0;
  int last_rise = 0;
  int per = 0;
  int rises = 0;
  int n;
  logic en4 = 1'b0;
  logic en5 = 1'b0;
  logic slow_q = 1'b0;
  logic third_q = 1'b0;

  itg_timer_irq dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .loop_clk_i(lclk), .loop_gate_i(lgate), .fast_out_o(fast), .slow_out_o(slow),
    .third_out_o(third), .irq_o(irq));
  itg_loop_model lm (.fast_i(fast), .slow_i(slow), .clk_o(lclk), .gate_o(lgate));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // cycle count, hang limit, slow period and third-channel edge tally
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    slow_q <= slow;
    third_q <= third;
    if (slow && !slow_q) begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (third && !third_q) rises <= rises + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one single transfer; waits on hready, never on a fixed latency
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= itg_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  function automatic logic [31:0] st_word(input logic s0, input logic s1);
    st_word = {26'h0, en5, en4, 2'h0, s1, s0};
  endfunction : st_word

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    // reset contents, local status and mask, an unmapped word
    bus(1'b0, itg_pkg::ADDR_ST_EN, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, itg_pkg::ADDR_LOC_ST, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, itg_pkg::ADDR_LOC_MASK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 16'h4000, 32'h0);
    chk(rd, 32'h0);
    // random data never loads the enables, each write only toggles
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, i[0] ? itg_pkg::ADDR_ST_CLR : itg_pkg::ADDR_ST_EN, $random(seed));
      if (i[0]) en5 = ~en5;
      else en4 = ~en4;
      bus(1'b0, itg_pkg::ADDR_ST_EN, 32'h0);
      chk(rd, st_word(1'b0, 1'b0));
    end
    // slow terminal count, interrupt disabled; count kept above 2
    n = 3 + ($unsigned($random(seed)) % 8);
    bus(1'b1, 16'h4034, n);
    chk({31'h0, slow}, 32'h0);
    repeat ((n - 1) * 10 - 2) @(posedge mclk_i);
    chk({31'h0, slow}, 32'h0);
    repeat (17) @(posedge mclk_i);
    chk({31'h0, slow}, 32'h1);
    repeat (6) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, itg_pkg::ADDR_ST_CLR, 32'h0);
    chk(rd, st_word(1'b0, 1'b1));
    bus(1'b0, itg_pkg::ADDR_ST_EN, 32'h0);
    chk(rd, st_word(1'b0, 1'b0));
    // same again with the enable set: the edge now raises irq
    bus(1'b1, itg_pkg::ADDR_ST_CLR, $random(seed));
    en5 = 1'b1;
    bus(1'b1, 16'h4034, n);
    chk({31'h0, irq}, 32'h0);
    repeat (n * 10 + 20) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, itg_pkg::ADDR_ST_CLR, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, itg_pkg::ADDR_ST_CLR, 32'h0);
    en5 = 1'b0;
    // slow square wave of count 6 gives a 60-cycle period
    bus(1'b1, 16'h4030, {29'h0, itg_pkg::MODE_SQUARE});
    bus(1'b1, 16'h4034, 32'h6);
    repeat (200) @(posedge mclk_i);
    chk(per, 6 * itg_pkg::SRC_DIV);
    // fast terminal count through the local edge input and its mask
    bus(1'b1, 16'h402C, 32'h3);
    repeat (60) @(posedge mclk_i);
    bus(1'b0, itg_pkg::ADDR_LOC_ST, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, itg_pkg::ADDR_LOC_MASK, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, itg_pkg::ADDR_LOC_ST, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, itg_pkg::ADDR_LOC_MASK, 32'h0);
    // loopback: fast clocks the third channel, slow gates it
    bus(1'b1, 16'h4028, {29'h0, itg_pkg::MODE_SQUARE});
    bus(1'b1, 16'h402C, 32'h2);
    bus(1'b1, 16'h4034, 32'h14);
    bus(1'b1, 16'h4020, {29'h0, itg_pkg::MODE_ONESHOT});
    bus(1'b1, 16'h4024, 32'h3);
    bus(1'b1, itg_pkg::ADDR_ST_EN, $random(seed));
    repeat (100) @(posedge mclk_i);
    rises = 0;
    repeat (1000) @(posedge mclk_i);
    // five gate periods fit the window: four to six edges
    chk({31'h0, rises >= 4 && rises <= 6}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, itg_pkg::ADDR_ST_EN, 32'h0);
    chk(rd & 32'h0000_0011, 32'h0000_0011);
    test_done();
  end
endmodule : tb
